// File: edge_sync.v
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter WIDTH     = 8,
  parameter RISE_MASK = 8'h33
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             srst_in,
  // pins and detected edges
  input  wire [WIDTH-1:0] line_in,
  output reg  [WIDTH-1:0] edge_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] prev;
  genvar i;
  always @(posedge clk_in) begin
    if (srst_in) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      prev   <= {WIDTH{1'b0}};
    end else begin
      stage1 <= line_in;
      stage2 <= stage1;
      prev   <= stage2;
    end
  end
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_line
      always @(posedge clk_in) begin
        if (srst_in) begin
          edge_out[i] <= 1'b0;
        end else if (RISE_MASK[i]) begin
          edge_out[i] <= stage2[i] & ~prev[i];
        end else begin
          edge_out[i] <= ~stage2[i] & prev[i];
        end
      end
    end
  endgenerate
endmodule // edge_sync
`default_nettype wire

// File: interrupt_and_reset_control.v
`include "irq_reset_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_reset_control #(
  parameter STRETCH_CYCLES = `STRETCH_CYCLES
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        srst_in,
  // reset sources and reset pin
  input  wire        supply_droop_detector_in,
  input  wire        droop_disable_in,
  input  wire        watchdog_reset_in,
  input  wire        reset_pin_n_in,
  output reg         reset_pin_out,
  output reg         reset_pin_oe_out,
  // reset side effects
  output reg         periph_reset_out,
  output reg  [15:0] timer_count_reset_out,
  output reg         osc_enable_out,
  output reg         timer_clock_enable_out,
  output reg         halt_latch_out,
  output reg         wait_latch_out,
  // cpu core
  input  wire        instr_boundary_in,
  input  wire        trap_instr_in,
  input  wire        wait_instr_in,
  input  wire        halt_instr_in,
  input  wire        irq_return_instr_in,
  input  wire [7:0]  popped_flags_in,
  input  wire        flags_wr_in,
  input  wire [7:0]  flags_data_in,
  input  wire [15:0] program_counter_in,
  input  wire [7:0]  x_index_in,
  input  wire [7:0]  accumulator_in,
  output reg         cpu_hold_out,
  output reg  [7:0]  condition_flags_reg_out,
  output reg  [15:0] stack_pointer_out,
  output reg         stack_wr_out,
  output reg  [15:0] stack_addr_out,
  output reg  [7:0]  stack_data_out,
  output reg         mem_rd_out,
  output reg  [15:0] mem_addr_out,
  input  wire [7:0]  mem_data_in,
  output reg         pc_load_out,
  output reg  [15:0] program_counter_out,
  // external lines and their enable register
  input  wire [7:0]  external_irq_line_in,
  input  wire        edge_en_wr_in,
  input  wire [7:0]  edge_en_data_in,
  output reg  [7:0]  edge_irq_enable_reg_out,
  output reg  [7:0]  ext_pending_out,
  // peripheral flags: end suspend, timer, two-wire, serial, usb
  input  wire [4:0]  periph_event_in,
  input  wire [4:0]  periph_enable_in,
  input  wire [4:0]  status_zero_wr_in,
  input  wire [4:0]  status_access_in,
  input  wire [4:0]  assoc_access_in,
  output wire [4:0]  periph_flag_out
);
  localparam ST_RESET   = 4'd0;
  localparam ST_STRETCH = 4'd1;
  localparam ST_VEC_HI  = 4'd2;
  localparam ST_VEC_LO  = 4'd3;
  localparam ST_VEC_END = 4'd4;
  localparam ST_RUN     = 4'd5;
  localparam ST_PUSH    = 4'd6;
  localparam ST_WAIT    = 4'd7;
  localparam ST_HALT    = 4'd8;
  localparam [12:0] STRETCH_LAST = STRETCH_CYCLES - 1;
  localparam [4:0]  WDG_LAST     = `WDG_PIN_CYCLES - 1;
  localparam [2:0]  PUSH_LAST    = `FRAME_BYTES - 1;
  localparam [5:0]  FRAME        = `FRAME_BYTES;

  reg  [3:0]  state;
  reg  [12:0] stretch_cnt;
  reg         from_halt;
  reg  [2:0]  push_idx;
  reg  [15:0] svc_vec;
  reg  [7:0]  vec_hi;
  reg  [15:0] saved_pc;
  reg  [7:0]  saved_x;
  reg  [7:0]  saved_a;
  reg  [7:0]  saved_cc;
  reg         droop_s1;
  reg         droop_s2;
  reg         pin_s1;
  reg         pin_s2;
  reg  [4:0]  wdg_cnt;
  reg         wdg_drive;
  wire [7:0]  ext_edge;
  wire        mask;
  wire        droop_active;
  wire        reset_any;
  reg         sel_hit;
  reg         sel_ext;
  reg  [15:0] sel_vec;
  reg         wake_halt;
  reg  [7:0]  push_byte;

  edge_sync #(
    .WIDTH     (8),
    .RISE_MASK (`EXT_RISE_MASK)
  ) u_edge_sync (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .line_in   (external_irq_line_in),
    .edge_out  (ext_edge)
  );

  periph_irq_latch #(
    .COUNT             (`SRC_COUNT)
  ) u_periph_irq_latch (
    .clk_in            (clk_in),
    .srst_in           (reset_any),
    .event_in          (periph_event_in),
    .status_zero_wr_in (status_zero_wr_in),
    .status_access_in  (status_access_in),
    .assoc_access_in   (assoc_access_in),
    .flag_out          (periph_flag_out)
  );

  // reset source synchronisers
  always @(posedge clk_in) begin
    if (srst_in) begin
      droop_s1 <= 1'b0;
      droop_s2 <= 1'b0;
      pin_s1   <= 1'b1;
      pin_s2   <= 1'b1;
    end else begin
      droop_s1 <= supply_droop_detector_in;
      droop_s2 <= droop_s1;
      pin_s1   <= reset_pin_n_in;
      pin_s2   <= pin_s1;
    end
  end

  assign droop_active = droop_s2 & ~droop_disable_in;
  assign reset_any    = srst_in | droop_active | watchdog_reset_in | ~pin_s2;
  assign mask         = condition_flags_reg_out[`CC_MASK_BIT];

  // watchdog reset pin pulse
  always @(posedge clk_in) begin
    if (srst_in) begin
      wdg_cnt   <= 5'h00;
      wdg_drive <= 1'b0;
    end else if (watchdog_reset_in) begin
      wdg_cnt   <= 5'h00;
      wdg_drive <= 1'b1;
    end else if (wdg_drive) begin
      wdg_cnt   <= wdg_cnt + 5'h01;
      wdg_drive <= (wdg_cnt != WDG_LAST);
    end
  end

  // pin drive is open drain, low only
  always @(posedge clk_in) begin
    if (srst_in) begin
      reset_pin_out    <= 1'b0;
      reset_pin_oe_out <= 1'b0;
    end else begin
      reset_pin_out    <= 1'b0;
      reset_pin_oe_out <= droop_active | wdg_drive | watchdog_reset_in;
    end
  end

  // priority selection of enabled pending requests
  always @* begin
    sel_hit = 1'b0;
    sel_ext = 1'b0;
    sel_vec = `VEC_USB;
    wake_halt = (|ext_pending_out) | (periph_flag_out[`SRC_END_SUSPEND] &
                periph_enable_in[`SRC_END_SUSPEND]);
    if (!mask) begin
      if (periph_flag_out[`SRC_END_SUSPEND] & periph_enable_in[`SRC_END_SUSPEND]) begin
        sel_hit = 1'b1;
        sel_vec = `VEC_END_SUSPEND;
      end else if (|ext_pending_out) begin
        sel_hit = 1'b1;
        sel_ext = 1'b1;
        sel_vec = `VEC_EXTERNAL;
      end else if (periph_flag_out[`SRC_TIMER] & periph_enable_in[`SRC_TIMER]) begin
        sel_hit = 1'b1;
        sel_vec = `VEC_TIMER;
      end else if (periph_flag_out[`SRC_TWOWIRE] & periph_enable_in[`SRC_TWOWIRE]) begin
        sel_hit = 1'b1;
        sel_vec = `VEC_TWOWIRE;
      end else if (periph_flag_out[`SRC_SERIAL] & periph_enable_in[`SRC_SERIAL]) begin
        sel_hit = 1'b1;
        sel_vec = `VEC_SERIAL;
      end else if (periph_flag_out[`SRC_USB] & periph_enable_in[`SRC_USB]) begin
        sel_hit = 1'b1;
        sel_vec = `VEC_USB;
      end
    end
  end

  // context byte for the current push slot
  always @* begin
    case (push_idx)
      3'd0:    push_byte = saved_pc[7:0];
      3'd1:    push_byte = saved_pc[15:8];
      3'd2:    push_byte = saved_x;
      3'd3:    push_byte = saved_a;
      default: push_byte = saved_cc;
    endcase
  end

  // edge enable register and latched pin requests
  always @(posedge clk_in) begin
    if (reset_any) begin
      edge_irq_enable_reg_out <= `EDGE_EN_RESET;
      ext_pending_out         <= 8'h00;
    end else begin
      if (edge_en_wr_in) begin
        edge_irq_enable_reg_out <= edge_en_data_in;
      end
      if (sel_ext && ((state == ST_RUN && instr_boundary_in && !trap_instr_in) ||
          state == ST_WAIT || (state == ST_STRETCH && from_halt &&
          stretch_cnt == STRETCH_LAST))) begin
        ext_pending_out <= ext_edge & edge_irq_enable_reg_out;
      end else begin
        ext_pending_out <= ext_pending_out | (ext_edge & edge_irq_enable_reg_out);
      end
    end
  end

  // sequencer
  always @(posedge clk_in) begin
    if (reset_any) begin
      state                   <= ST_RESET;
      stretch_cnt             <= 13'h0000;
      from_halt               <= 1'b0;
      push_idx                <= 3'd0;
      svc_vec                 <= `VEC_RESET;
      vec_hi                  <= 8'h00;
      saved_pc                <= 16'h0000;
      saved_x                 <= 8'h00;
      saved_a                 <= 8'h00;
      saved_cc                <= 8'h00;
      periph_reset_out        <= 1'b1;
      timer_count_reset_out   <= `TIMER_COUNT_RESET;
      osc_enable_out          <= 1'b0;
      timer_clock_enable_out  <= 1'b0;
      halt_latch_out          <= 1'b0;
      wait_latch_out          <= 1'b0;
      cpu_hold_out            <= 1'b1;
      condition_flags_reg_out <= `CC_RESET;
      stack_pointer_out       <= `SP_RESET;
      stack_wr_out            <= 1'b0;
      stack_addr_out          <= `SP_RESET;
      stack_data_out          <= 8'h00;
      mem_rd_out              <= 1'b0;
      mem_addr_out            <= 16'h0000;
      pc_load_out             <= 1'b0;
      program_counter_out     <= 16'h0000;
    end else begin
      stack_wr_out <= 1'b0;
      mem_rd_out   <= 1'b0;
      pc_load_out  <= 1'b0;
      case (state)
        ST_RESET: begin
          periph_reset_out <= 1'b0;
          osc_enable_out   <= 1'b1;
          stretch_cnt      <= 13'h0000;
          state            <= ST_STRETCH;
        end
        ST_STRETCH: begin
          stretch_cnt <= stretch_cnt + 13'h0001;
          if (stretch_cnt == STRETCH_LAST) begin
            timer_clock_enable_out <= 1'b1;
            if (from_halt) begin
              from_halt <= 1'b0;
              halt_latch_out <= 1'b0;
              if (sel_hit) begin
                svc_vec  <= sel_vec;
                saved_pc <= program_counter_in;
                saved_x  <= x_index_in;
                saved_a  <= accumulator_in;
                saved_cc <= condition_flags_reg_out;
                push_idx <= 3'd0;
                state    <= ST_PUSH;
              end else begin
                cpu_hold_out <= 1'b0;
                state        <= ST_RUN;
              end
            end else begin
              svc_vec <= `VEC_RESET;
              state   <= ST_VEC_HI;
            end
          end
        end
        ST_PUSH: begin
          stack_wr_out      <= 1'b1;
          stack_addr_out    <= stack_pointer_out;
          stack_data_out    <= push_byte;
          stack_pointer_out <= {`SP_FIXED_HIGH, stack_pointer_out[5:0] - 6'h01};
          push_idx          <= push_idx + 3'd1;
          if (push_idx == PUSH_LAST) begin
            condition_flags_reg_out[`CC_MASK_BIT] <= 1'b1;
            state <= ST_VEC_HI;
          end
        end
        ST_VEC_HI: begin
          mem_rd_out   <= 1'b1;
          mem_addr_out <= svc_vec;
          state        <= ST_VEC_LO;
        end
        ST_VEC_LO: begin
          vec_hi       <= mem_data_in;
          mem_rd_out   <= 1'b1;
          mem_addr_out <= svc_vec + 16'h0001;
          state        <= ST_VEC_END;
        end
        ST_VEC_END: begin
          program_counter_out <= {vec_hi, mem_data_in};
          pc_load_out         <= 1'b1;
          cpu_hold_out        <= 1'b0;
          state               <= ST_RUN;
        end
        ST_RUN: begin
          if (flags_wr_in) begin
            condition_flags_reg_out <= flags_data_in | `CC_FIXED_ONES;
          end
          if (irq_return_instr_in) begin
            condition_flags_reg_out <= popped_flags_in | `CC_FIXED_ONES;
            stack_pointer_out <= {`SP_FIXED_HIGH, stack_pointer_out[5:0] + FRAME};
          end
          if (instr_boundary_in) begin
            saved_pc <= program_counter_in;
            saved_x  <= x_index_in;
            saved_a  <= accumulator_in;
            saved_cc <= condition_flags_reg_out;
            push_idx <= 3'd0;
            if (trap_instr_in) begin
              svc_vec      <= `VEC_TRAP;
              cpu_hold_out <= 1'b1;
              state        <= ST_PUSH;
            end else if (sel_hit) begin
              svc_vec      <= sel_vec;
              cpu_hold_out <= 1'b1;
              state        <= ST_PUSH;
            end else if (halt_instr_in) begin
              condition_flags_reg_out[`CC_MASK_BIT] <= 1'b0;
              halt_latch_out         <= 1'b1;
              osc_enable_out         <= 1'b0;
              timer_clock_enable_out <= 1'b0;
              cpu_hold_out           <= 1'b1;
              state                  <= ST_HALT;
            end else if (wait_instr_in) begin
              condition_flags_reg_out[`CC_MASK_BIT] <= 1'b0;
              wait_latch_out <= 1'b1;
              cpu_hold_out   <= 1'b1;
              state          <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (sel_hit) begin
            wait_latch_out <= 1'b0;
            svc_vec        <= sel_vec;
            saved_pc       <= program_counter_in;
            saved_x        <= x_index_in;
            saved_a        <= accumulator_in;
            saved_cc       <= condition_flags_reg_out;
            push_idx       <= 3'd0;
            state          <= ST_PUSH;
          end
        end
        ST_HALT: begin
          if (wake_halt) begin
            osc_enable_out <= 1'b1;
            stretch_cnt    <= 13'h0000;
            from_halt      <= 1'b1;
            state          <= ST_STRETCH;
          end
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end
endmodule // interrupt_and_reset_control
`default_nettype wire

// File: interrupt_and_reset_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_reset_defs.vh"
module interrupt_and_reset_control_tb;
  logic        clk_in, srst_in, supply_droop_detector_in, droop_disable_in, watchdog_reset_in;
  logic        pin_drv, instr_boundary_in, trap_instr_in, wait_instr_in, halt_instr_in;
  logic        irq_return_instr_in, flags_wr_in, edge_en_wr_in;
  logic [7:0]  popped_flags_in, flags_data_in, x_index_in, accumulator_in;
  logic [7:0]  external_irq_line_in, edge_en_data_in;
  logic [15:0] program_counter_in;
  logic [4:0]  periph_event_in, periph_enable_in, status_zero_wr_in;
  logic [4:0]  status_access_in, assoc_access_in;
  wire         reset_pin_out, reset_pin_oe_out, periph_reset_out, osc_enable_out;
  wire         timer_clock_enable_out, halt_latch_out, wait_latch_out, cpu_hold_out;
  wire         stack_wr_out, mem_rd_out, pc_load_out;
  wire  [15:0] timer_count_reset_out, stack_pointer_out, stack_addr_out;
  wire  [15:0] mem_addr_out, program_counter_out;
  wire  [7:0]  condition_flags_reg_out, stack_data_out, edge_irq_enable_reg_out;
  wire  [7:0]  ext_pending_out, mem_data_in;
  wire  [4:0]  periph_flag_out;
  wire         reset_pin_n_in = pin_drv & ~reset_pin_oe_out;
  int          error_cnt, comparisons;
  logic [31:0] seed = 32'h394b;
  logic [31:0] rnd;
  logic [15:0] ctx_prog, stk_top, got;
  logic [7:0]  cx, ca, r;
  logic [15:0] vec [6] = '{`VEC_END_SUSPEND, `VEC_EXTERNAL, `VEC_TIMER, `VEC_SERIAL,
                           `VEC_USB, `VEC_TWOWIRE};
  int          src [6] = '{0, 8, 1, 3, 4, 2};

  interrupt_and_reset_control #(.STRETCH_CYCLES(8)) i_dut (.*);
  vector_mem_model i_mem (.clk_in(clk_in), .rd_in(mem_rd_out), .addr_in(mem_addr_out),
    .wr_in(stack_wr_out), .waddr_in(stack_addr_out), .wdata_in(stack_data_out),
    .data_out(mem_data_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] vec_word(logic [15:0] v);
    return {v[7:0] ^ 8'h5a, (v[7:0] + 8'h1) ^ 8'h5a};
  endfunction
  task check(string nm, logic [79:0] seen, logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task boundary(logic t, logic w, logic h);
    rnd = xs();
    {ctx_prog, cx, ca} = rnd;
    stk_top = stack_pointer_out;
    {program_counter_in, x_index_in, accumulator_in} = rnd;
    {instr_boundary_in, trap_instr_in, wait_instr_in, halt_instr_in} = {1'b1, t, w, h};
    tick(1);
    {instr_boundary_in, trap_instr_in, wait_instr_in, halt_instr_in} = 4'h0;
  endtask
  task wait_load();
    for (int i = 0; i < 100 && pc_load_out !== 1'b1; i++) tick(1);
    check("load", pc_load_out, 1'b1);
    got = program_counter_out;
  endtask
  task finish(logic [15:0] v, logic [7:0] f);
    logic [39:0] fr;
    wait_load();
    for (int i = 0; i < 5; i++) fr = {fr[31:0], i_mem.stk[stk_top[7:0] - i[7:0]]};
    check("svc", {got, fr, stack_pointer_out, condition_flags_reg_out[3]},
      {vec_word(v), ctx_prog[7:0], ctx_prog[15:8], cx, ca, f, stk_top - 16'h5, 1'b1});
    tick(1);
  endtask
  task ret(logic [7:0] f);
    stk_top = stack_pointer_out;
    popped_flags_in = f;
    irq_return_instr_in = 1'b1;
    tick(1);
    irq_return_instr_in = 1'b0;
    tick(1);
    check("return", {stack_pointer_out, condition_flags_reg_out}, {stk_top + 16'h5, f});
  endtask
  task wflags(logic [7:0] f);
    flags_data_in = f;
    flags_wr_in = 1'b1;
    tick(1);
    flags_wr_in = 1'b0;
  endtask
  task edges(logic [7:0] en, logic [7:0] exp);
    edge_en_data_in = en;
    edge_en_wr_in = 1'b1;
    tick(1);
    edge_en_wr_in = 1'b0;
    external_irq_line_in ^= 8'hff;
    tick(6);
    check("pending", ext_pending_out, exp);
  endtask
  task clear(int s, logic z);
    status_zero_wr_in[s] = z;
    status_access_in[s] = !z;
    tick(1);
    {status_zero_wr_in, status_access_in} = 10'h0;
    assoc_access_in[s] = !z;
    tick(1);
    assoc_access_in = 5'h0;
    tick(1);
    check("clr", periph_flag_out[s], 1'b0);
  endtask
  task pulse_event(logic [4:0] e);
    periph_event_in = e;
    tick(1);
    periph_event_in = 5'h0;
  endtask

  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end

  initial begin
    {srst_in, pin_drv, supply_droop_detector_in, droop_disable_in, watchdog_reset_in} = 5'h18;
    {instr_boundary_in, trap_instr_in, wait_instr_in, halt_instr_in} = 4'h0;
    {irq_return_instr_in, flags_wr_in, edge_en_wr_in} = 3'h0;
    {popped_flags_in, flags_data_in, x_index_in, accumulator_in, edge_en_data_in} = 40'h0;
    program_counter_in = 16'h0;
    external_irq_line_in = ~`EXT_RISE_MASK;
    {periph_event_in, status_zero_wr_in, status_access_in, assoc_access_in} = 20'h0;
    periph_enable_in = 5'h1b;
    tick(6);
    check("rst", {stack_pointer_out, condition_flags_reg_out, timer_count_reset_out,
      edge_irq_enable_reg_out, osc_enable_out, timer_clock_enable_out, halt_latch_out,
      wait_latch_out, periph_reset_out, cpu_hold_out}, {`SP_RESET, `CC_RESET,
      `TIMER_COUNT_RESET, `EDGE_EN_RESET, 6'h3});
    srst_in = 1'b0;
    wait_load();
    check("rvec", got, vec_word(`VEC_RESET));
    tick(1);
    repeat (2) begin
      boundary(1'b1, 1'b0, 1'b0);
      finish(`VEC_TRAP, `CC_RESET);
    end
    ret(`CC_RESET);
    ret(8'he0);
    wflags(`CC_RESET);
    edges(8'h00, 8'h00);
    edges(8'hff, 8'h00);
    rnd = xs();
    r = rnd[7:0] | 8'h01;
    edges(r, r);
    pulse_event(5'h1f);
    boundary(1'b0, 1'b0, 1'b0);
    tick(2);
    check("masked", {cpu_hold_out, periph_flag_out}, {1'b0, 5'h1f});
    wflags(8'he0);
    for (int k = 0; k < 6; k++) begin
      if (k == 5) periph_enable_in = 5'h1f;
      boundary(1'b0, 1'b0, 1'b0);
      finish(vec[k], 8'he0);
      if (src[k] < 8) clear(src[k], k[0]);
      ret(8'he0);
    end
    check("all clear", {ext_pending_out, periph_flag_out}, 13'h0);
    pulse_event(5'h02);
    wflags(`CC_RESET);
    boundary(1'b0, 1'b1, 1'b0);
    finish(`VEC_TIMER, 8'he0);
    clear(1, 1'b1);
    ret(8'he0);
    wflags(`CC_RESET);
    boundary(1'b0, 1'b0, 1'b1);
    tick(2);
    check("halt entry", {osc_enable_out, halt_latch_out, condition_flags_reg_out},
      {2'b01, 8'he0});
    pulse_event(5'h02);
    tick(20);
    check("halt kept", {halt_latch_out, mem_rd_out}, 2'b10);
    external_irq_line_in ^= 8'hff;
    tick(2);
    external_irq_line_in ^= 8'hff;
    finish(`VEC_EXTERNAL, 8'he0);
    clear(1, 1'b0);
    ret(8'he0);
    {supply_droop_detector_in, droop_disable_in} = 2'b11;
    tick(6);
    check("off", {reset_pin_oe_out, periph_reset_out, ext_pending_out}, 10'h0);
    for (int k = 0; k < 3; k++) begin
      {supply_droop_detector_in, watchdog_reset_in, pin_drv} = {k == 0, k == 1, k != 2};
      droop_disable_in = 1'b0;
      tick(4);
      check("reset pin", {reset_pin_oe_out, periph_reset_out}, {k < 2, 1'b1});
      {supply_droop_detector_in, watchdog_reset_in, pin_drv} = 3'b001;
      wait_load();
      check("restart", got, vec_word(`VEC_RESET));
      tick(1);
    end
    complete_run();
  end
endmodule // interrupt_and_reset_control_tb
`default_nettype wire

// File: irq_reset_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_reset_defs.vh"
module irq_reset_checker #(
  parameter STRETCH_CYCLES = 8
) (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        srst_in,
  // reset sources and effects
  input wire logic        supply_droop_detector_in,
  input wire logic        droop_disable_in,
  input wire logic        watchdog_reset_in,
  input wire logic        reset_pin_oe_out,
  input wire logic        periph_reset_out,
  input wire logic        osc_enable_out,
  input wire logic        halt_latch_out,
  // cpu side
  input wire logic        instr_boundary_in,
  input wire logic        trap_instr_in,
  input wire logic        wait_instr_in,
  input wire logic        halt_instr_in,
  input wire logic        cpu_hold_out,
  input wire logic [7:0]  condition_flags_reg_out,
  input wire logic [15:0] stack_pointer_out,
  input wire logic        stack_wr_out,
  input wire logic        mem_rd_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic        pc_load_out,
  // request sources
  input wire logic [7:0]  external_irq_line_in,
  input wire logic [7:0]  edge_irq_enable_reg_out,
  input wire logic [7:0]  ext_pending_out,
  input wire logic [4:0]  periph_event_in,
  input wire logic [4:0]  status_zero_wr_in,
  input wire logic [4:0]  periph_flag_out
);
  logic        first;
  logic [15:0] cnt;
  logic [7:0]  line_q;
  logic [4:0]  evt;
  logic [4:0]  zclr;
  wire  [7:0]  hit = (external_irq_line_in & ~line_q & `EXT_RISE_MASK)
                   | (~external_irq_line_in & line_q & ~`EXT_RISE_MASK);
  wire         mask_bit = condition_flags_reg_out[`CC_MASK_BIT];

  always @(posedge clk_in) begin
    line_q <= external_irq_line_in;
    evt    <= periph_event_in;
    zclr   <= status_zero_wr_in & ~periph_event_in;
    if (srst_in || periph_reset_out) begin
      first <= 1'b1;
      cnt   <= 16'h0;
    end else begin
      cnt <= cnt + 16'h1;
      if (pc_load_out) first <= 1'b0;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence push_frame;
    stack_wr_out [*5];
  endsequence
  sequence fetch_vec;
    mem_rd_out ##1 mem_rd_out ##1 pc_load_out;
  endsequence

  wdg_reset_a: assert property (watchdog_reset_in |-> ##[1:2] (periph_reset_out && cpu_hold_out))
    else $error("no wdg reset");
  droop_pin_a: assert property ((supply_droop_detector_in && !droop_disable_in) [*4]
    |-> reset_pin_oe_out)
    else $error("droop pin");
  wdg_pin_a: assert property (watchdog_reset_in |-> ##[1:3] reset_pin_oe_out [*8])
    else $error("wdg pin");
  stretch_len_a: assert property ((pc_load_out && first)
    |-> (cnt >= STRETCH_CYCLES && cnt <= STRETCH_CYCLES + 4))
    else $error("stretch");
  reset_vec_a: assert property ((pc_load_out && first) |-> mem_addr_out == `VEC_RESET + 16'h1)
    else $error("reset vector");
  trap_service_a: assert property ((instr_boundary_in && trap_instr_in && !cpu_hold_out)
    |=> cpu_hold_out ##1 push_frame ##1 fetch_vec)
    else $error("trap service");
  mask_entry_a: assert property (pc_load_out |-> mask_bit)
    else $error("entry mask");
  masked_idle_a: assert property ((mask_bit && instr_boundary_in
    && !cpu_hold_out && !(trap_instr_in || wait_instr_in || halt_instr_in))
    |=> !cpu_hold_out)
    else $error("masked service");
  ext_edge_a: assert property (|(hit & edge_irq_enable_reg_out)
    |-> ##[3:6] (|ext_pending_out || cpu_hold_out))
    else $error("pin edge");
  flag_clear_a: assert property (|zclr |-> (periph_flag_out & zclr) == 5'h0)
    else $error("zero write");
  flag_latch_a: assert property ((|evt && !periph_reset_out)
    |-> (periph_flag_out & evt) == evt)
    else $error("flag latch");
  halt_entry_a: assert property ((instr_boundary_in && halt_instr_in && !trap_instr_in
    && !cpu_hold_out && mask_bit) |=> ##[0:1]
    (!osc_enable_out && halt_latch_out && !mask_bit))
    else $error("halt entry");
  reset_state_a: assert property (periph_reset_out |-> (stack_pointer_out == `SP_RESET
    && condition_flags_reg_out == `CC_RESET && !osc_enable_out
    && edge_irq_enable_reg_out == `EDGE_EN_RESET))
    else $error("reset values");
endmodule // irq_reset_checker

bind interrupt_and_reset_control irq_reset_checker #(
  .STRETCH_CYCLES(STRETCH_CYCLES)
) i_chk (.*);
`default_nettype wire

// File: irq_reset_defs.vh
`ifndef IRQ_RESET_DEFS_VH
`define IRQ_RESET_DEFS_VH

// reset stretch after oscillator start, in cpu clock cycles
`define STRETCH_CYCLES      4096
// cycles the reset pin is driven low after a watchdog reset
`define WDG_PIN_CYCLES      16

// vector addresses, high byte at the even address
`define VEC_RESET           16'hfffe
`define VEC_TRAP            16'hfffc
`define VEC_END_SUSPEND     16'hfffa
`define VEC_EXTERNAL        16'hfff8
`define VEC_TIMER           16'hfff6
`define VEC_TWOWIRE         16'hfff4
`define VEC_SERIAL          16'hfff2
`define VEC_USB             16'hfff0

// reset values
`define SP_RESET            16'h013f
`define SP_FIXED_HIGH       10'h004
`define TIMER_COUNT_RESET   16'hfffc
`define EDGE_EN_RESET       8'h00
`define CC_RESET            8'he8

// condition code fields
`define CC_MASK_BIT         3
`define CC_FIXED_ONES       8'he0

// peripheral source indices
`define SRC_END_SUSPEND     0
`define SRC_TIMER           1
`define SRC_TWOWIRE         2
`define SRC_SERIAL          3
`define SRC_USB             4
`define SRC_COUNT           5

// edge polarity per external line, bit set = rising edge
`define EXT_RISE_MASK       8'h33

// context frame size in stack bytes
`define FRAME_BYTES         5

`endif

// File: periph_irq_latch.v
`timescale 1ns/1ps
`default_nettype none
module periph_irq_latch #(
  parameter COUNT = 5
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             srst_in,
  // events and clearing accesses
  input  wire [COUNT-1:0] event_in,
  input  wire [COUNT-1:0] status_zero_wr_in,
  input  wire [COUNT-1:0] status_access_in,
  input  wire [COUNT-1:0] assoc_access_in,
  // latched flags
  output reg  [COUNT-1:0] flag_out
);
  reg [COUNT-1:0] armed;
  genvar i;
  generate
    for (i = 0; i < COUNT; i = i + 1) begin : g_src
      always @(posedge clk_in) begin
        if (srst_in) begin
          flag_out[i] <= 1'b0;
          armed[i]    <= 1'b0;
        end else begin
          if (event_in[i]) begin
            flag_out[i] <= 1'b1;
          end else if (status_zero_wr_in[i] | (armed[i] & assoc_access_in[i])) begin
            flag_out[i] <= 1'b0;
          end
          if (status_access_in[i] & flag_out[i]) begin
            armed[i] <= 1'b1;
          end else if (assoc_access_in[i] | status_zero_wr_in[i]) begin
            armed[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // periph_irq_latch
`default_nettype wire

// File: vector_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module vector_mem_model (
  // clock
  input wire logic        clk_in,
  // vector reads and stack writes
  input wire logic        rd_in,
  input wire logic [15:0] addr_in,
  input wire logic        wr_in,
  input wire logic [15:0] waddr_in,
  input wire logic [7:0]  wdata_in,
  output logic     [7:0]  data_out
);
  logic [7:0] stk [0:255];
  logic [7:0] idle = 8'h00;

  always @(posedge clk_in) begin
    if (wr_in) stk[waddr_in[7:0]] <= wdata_in;
    idle <= ~idle;
  end
  assign data_out = rd_in ? addr_in[7:0] ^ 8'h5a : idle;
endmodule // vector_mem_model
`default_nettype wire
